// ---- pkg/dcw_pkg.sv ----
// package: constants and types for the drive control word decoder
package dcw_pkg;
	// ------------------------------------------------------------
	// register offsets (word index on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_COMMAND = 4'h0;
	localparam logic [3:0] ADDR_MODE = 4'h1;
	localparam logic [3:0] ADDR_STATE_REPORT = 4'h2;
	localparam logic [3:0] ADDR_EVENT_STATUS = 4'h3;
	localparam logic [3:0] ADDR_EVENT_MASK = 4'h4;
	localparam logic [3:0] ADDR_FAULT_CTRL = 4'h5;
	localparam logic [3:0] ADDR_MOTION_CTRL = 4'h6;
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	localparam logic [15:0] COMMAND_RESERVED_MASK = 16'hfe00;
	// ------------------------------------------------------------
	// command word bit positions
	// ------------------------------------------------------------
	localparam int BIT_SWITCH_ON = 0;
	localparam int BIT_ENABLE_VOLTAGE = 1;
	localparam int BIT_QUICK_STOP_N = 2;
	localparam int BIT_ENABLE_OPERATION = 3;
	localparam int BIT_NEW_SET_POINT = 4;
	localparam int BIT_CHANGE_IMMEDIATE = 5;
	localparam int BIT_RELATIVE = 6;
	localparam int BIT_FAULT_RESET = 7;
	localparam int BIT_HALT = 8;
	// ------------------------------------------------------------
	// state report word bit positions
	// ------------------------------------------------------------
	localparam int REPORT_VOLTAGE_ENABLED = 4;
	localparam int REPORT_TARGET_REACHED = 10;
	localparam int REPORT_MODE_FLAG = 12;
	localparam int REPORT_HOMING_ERROR = 13;
	// event status bits
	localparam int EVT_COMMAND = 0;
	localparam int EVT_FAULT_CLEARED = 1;
	localparam int EVT_FAULT_RESET_FAIL = 2;
	localparam int EVT_HOMING_ERROR = 3;
	localparam int EVT_TARGET_REACHED = 4;
	localparam int EVT_WIDTH = 5;

	typedef enum logic [2:0] {
		OPMODE_NONE = 3'b000,
		OPMODE_PROFILE_POSITION = 3'b001,
		OPMODE_PROFILE_VELOCITY = 3'b011,
		OPMODE_PROFILE_TORQUE = 3'b100,
		OPMODE_HOMING = 3'b110,
		OPMODE_INTERPOLATED = 3'b111
	} dcw_opmode_type;

	typedef enum logic [3:0] {
		ST_NOT_READY = 4'b0000,
		ST_SWITCH_ON_DISABLED = 4'b0001,
		ST_READY_TO_SWITCH_ON = 4'b0010,
		ST_SWITCHED_ON = 4'b0011,
		ST_OPERATION_ENABLED = 4'b0100,
		ST_QUICK_STOP_ACTIVE = 4'b0101,
		ST_FAULT = 4'b0110
	} dcw_state_type;

	// state report word encodings for bits 6,5,3..0
	localparam logic [15:0] RPT_NOT_READY = 16'h0000;
	localparam logic [15:0] RPT_SWITCH_ON_DISABLED = 16'h0040;
	localparam logic [15:0] RPT_READY = 16'h0021;
	localparam logic [15:0] RPT_SWITCHED_ON = 16'h0023;
	localparam logic [15:0] RPT_OPERATION_ENABLED = 16'h0027;
	localparam logic [15:0] RPT_QUICK_STOP = 16'h0007;
	localparam logic [15:0] RPT_FAULT = 16'h000f;

	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} dcw_bus_req_type;

	// motion strobes handed to the profile generators
	typedef struct packed {
		logic take_set_point;
		logic change_immediate;
		logic relative;
		logic homing_start;
		logic homing_stop;
		logic interp_enable;
		logic halt_position;
		logic halt_ramp;
		logic halt_torque;
	} dcw_motion_type;
endpackage : dcw_pkg

// ---- verilog/dcw_decoder.sv ----
// drive control word decoder: command word, drive state machine, mode bits
//
// Overview of operation
// - bits 2..0 give shutdown, switch on, quick stop
// - bits 3..0 give disable or enable operation
// - bit 7 rising edge clears fault if cleared
// - bits 4,5,6,8 meaning follows operating mode
// - position mode: bit 4 rise takes set point
// - homing: bit 4 rise starts, fall stops
// - interpolated: bit 4 enables, reported active
// - bit 5 clear waits, set interrupts order
// - bit 6 set makes target relative
// - position halt cancels, flags target reached
// - velocity halt ramps to zero, release resumes
// - torque halt ramps torque to zero
// - homing halt cancels and raises homing error
// - 16-bit command resets zero, reserved bits zero
// - bit 12 of report depends on mode
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module dcw_decoder
	import dcw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire dcw_bus_req_type bus_req,
	output logic [15:0] rdata,
	input wire logic fault_cause,
	input wire logic motion_done,
	input wire logic homing_done,
	output dcw_motion_type motion,
	output logic power_stage_on,
	output logic irq
);
	// ------------------------------------------------------------
	// reset release and fault pin synchroniser
	// ------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;
	logic [2:0] fault_sync;
	logic fault_now;

	// reset asserts at once and releases two edges later
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// fault cause comes from outside; a change counts once stages 2 and 3 agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fault_sync <= 3'b000;
			fault_now <= 1'b0;
		end else begin
			fault_sync <= {fault_sync[1:0], fault_cause};
			if (fault_sync[2] == fault_sync[1]) begin
				fault_now <= fault_sync[2];
			end
		end
	end

	// ------------------------------------------------------------
	// command word and edge detection
	// ------------------------------------------------------------
	logic [15:0] command;
	logic [15:0] command_prev;
	logic cmd_strobe;
	dcw_opmode_type opmode;
	logic [15:0] wr_word;

	assign wr_word = bus_req.wdata & ~COMMAND_RESERVED_MASK;
	// previous copy held so each write is compared with the one before
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			command <= COMMAND_RESET;
			command_prev <= COMMAND_RESET;
			cmd_strobe <= 1'b0;
		end else begin
			cmd_strobe <= bus_req.wr && bus_req.addr == ADDR_COMMAND;
			if (bus_req.wr && bus_req.addr == ADDR_COMMAND) begin
				command_prev <= command;
				command <= wr_word;
			end
		end
	end

	// operating mode selection; unknown codes fall back to none
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			opmode <= OPMODE_NONE;
		end else if (bus_req.wr && bus_req.addr == ADDR_MODE) begin
			unique case (bus_req.wdata[2:0])
				3'b001: opmode <= OPMODE_PROFILE_POSITION;
				3'b011: opmode <= OPMODE_PROFILE_VELOCITY;
				3'b100: opmode <= OPMODE_PROFILE_TORQUE;
				3'b110: opmode <= OPMODE_HOMING;
				3'b111: opmode <= OPMODE_INTERPOLATED;
				default: opmode <= OPMODE_NONE;
			endcase
		end
	end

	logic rise4;
	logic fall4;
	logic rise7;
	logic rise8;
	// edges valid only in the cycle after the write
	assign rise4 = cmd_strobe && command[BIT_NEW_SET_POINT] && !command_prev[BIT_NEW_SET_POINT];
	assign fall4 = cmd_strobe && !command[BIT_NEW_SET_POINT] && command_prev[BIT_NEW_SET_POINT];
	assign rise7 = cmd_strobe && command[BIT_FAULT_RESET] && !command_prev[BIT_FAULT_RESET];
	assign rise8 = cmd_strobe && command[BIT_HALT] && !command_prev[BIT_HALT];

	// ------------------------------------------------------------
	// drive state machine
	// ------------------------------------------------------------
	dcw_state_type state;
	dcw_state_type next_state;
	logic fault_cleared;
	logic fault_fail;

	// next state from the low command bits; a bit 7 rising edge counts only in the fault state
	always_comb begin
		next_state = state;
		fault_cleared = 1'b0;
		fault_fail = 1'b0;
		unique case (state)
			ST_NOT_READY: next_state = ST_SWITCH_ON_DISABLED;
			ST_FAULT: begin
				if (rise7) begin
					if (!fault_now) begin
						next_state = ST_SWITCH_ON_DISABLED;
						fault_cleared = 1'b1;
					end else begin
						fault_fail = 1'b1;
					end
				end
			end
			default: begin
				if (cmd_strobe) begin
					if (!command[BIT_ENABLE_VOLTAGE]) begin
						next_state = ST_SWITCH_ON_DISABLED;
					end else if (!command[BIT_QUICK_STOP_N]) begin
						if (state == ST_OPERATION_ENABLED) begin
							next_state = ST_QUICK_STOP_ACTIVE;
						end else begin
							next_state = ST_SWITCH_ON_DISABLED;
						end
					end else if (!command[BIT_SWITCH_ON]) begin
						if (state != ST_QUICK_STOP_ACTIVE) begin
							next_state = ST_READY_TO_SWITCH_ON;
						end
					end else if (command[BIT_ENABLE_OPERATION]) begin
						if (state != ST_SWITCH_ON_DISABLED) begin
							next_state = ST_OPERATION_ENABLED;
						end
					end else if (state == ST_READY_TO_SWITCH_ON
						|| state == ST_OPERATION_ENABLED) begin
						next_state = ST_SWITCHED_ON;
					end
				end
				if (fault_now) begin
					next_state = ST_FAULT;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_NOT_READY;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// mode dependent bits and state report flags
	// ------------------------------------------------------------
	logic op_en;
	logic homing_busy;
	logic homing_err;
	logic target_reached;
	logic pos_halting;
	logic set_point_ack;
	assign op_en = state == ST_OPERATION_ENABLED;

	// strobes and levels toward the motion generators, selected by mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			motion <= '0;
			power_stage_on <= 1'b0;
		end else begin
			power_stage_on <= op_en || state == ST_QUICK_STOP_ACTIVE;
			motion.take_set_point <= op_en && opmode == OPMODE_PROFILE_POSITION
				&& rise4;
			motion.change_immediate <= command[BIT_CHANGE_IMMEDIATE]
				&& opmode == OPMODE_PROFILE_POSITION;
			motion.relative <= command[BIT_RELATIVE]
				&& opmode == OPMODE_PROFILE_POSITION;
			motion.homing_start <= op_en && opmode == OPMODE_HOMING && rise4;
			motion.homing_stop <= opmode == OPMODE_HOMING && homing_busy
				&& (fall4 || rise8);
			motion.interp_enable <= op_en && opmode == OPMODE_INTERPOLATED
				&& command[BIT_NEW_SET_POINT];
			motion.halt_position <= opmode == OPMODE_PROFILE_POSITION && rise8;
			motion.halt_ramp <= opmode == OPMODE_PROFILE_VELOCITY
				&& command[BIT_HALT];
			motion.halt_torque <= opmode == OPMODE_PROFILE_TORQUE
				&& command[BIT_HALT];
		end
	end

	// homing progress; halt cancels and flags an error until next start
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			homing_busy <= 1'b0;
			homing_err <= 1'b0;
		end else if (opmode == OPMODE_HOMING && rise4 && op_en) begin
			homing_busy <= 1'b1;
			homing_err <= 1'b0;
		end else if (homing_busy && rise8) begin
			homing_busy <= 1'b0;
			homing_err <= 1'b1;
		end else if (homing_busy && (fall4 || homing_done || !op_en)) begin
			homing_busy <= 1'b0;
		end
	end

	// target reached: set when the halted or finished order has stopped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			target_reached <= 1'b0;
			pos_halting <= 1'b0;
			set_point_ack <= 1'b0;
		end else begin
			if (motion.halt_position) begin
				pos_halting <= 1'b1;
			end else if (motion_done) begin
				pos_halting <= 1'b0;
			end
			if (motion_done) begin
				target_reached <= 1'b1;
			end else if (motion.take_set_point) begin
				target_reached <= 1'b0;
			end
			if (motion.take_set_point) begin
				set_point_ack <= 1'b1;
			end else if (cmd_strobe && !command[BIT_NEW_SET_POINT]) begin
				set_point_ack <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// state report word
	// ------------------------------------------------------------
	logic [15:0] report;
	logic mode_flag;
	always_comb begin
		unique case (opmode)
			OPMODE_PROFILE_POSITION: mode_flag = set_point_ack;
			OPMODE_HOMING: mode_flag = homing_done && !homing_busy && !homing_err;
			OPMODE_INTERPOLATED: mode_flag = motion.interp_enable;
			default: mode_flag = 1'b0;
		endcase
	end

	always_comb begin
		unique case (state)
			ST_SWITCH_ON_DISABLED: report = RPT_SWITCH_ON_DISABLED;
			ST_READY_TO_SWITCH_ON: report = RPT_READY;
			ST_SWITCHED_ON: report = RPT_SWITCHED_ON;
			ST_OPERATION_ENABLED: report = RPT_OPERATION_ENABLED;
			ST_QUICK_STOP_ACTIVE: report = RPT_QUICK_STOP;
			ST_FAULT: report = RPT_FAULT;
			default: report = RPT_NOT_READY;
		endcase
		report[REPORT_VOLTAGE_ENABLED] = power_stage_on;
		report[REPORT_TARGET_REACHED] = target_reached;
		report[REPORT_MODE_FLAG] = mode_flag;
		report[REPORT_HOMING_ERROR] = homing_err;
	end

	// ------------------------------------------------------------
	// events and interrupt
	// ------------------------------------------------------------
	logic [EVT_WIDTH-1:0] evt_status;
	logic [EVT_WIDTH-1:0] evt_mask;
	logic [EVT_WIDTH-1:0] evt_set;
	// homing halt is taken from the live busy flag; the registered stop strobe lags rise8
	assign evt_set = {motion_done, homing_busy && rise8, fault_fail, fault_cleared,
		state != next_state};

	// write one clears; a new event in the same cycle wins over the clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evt_status <= '0;
			evt_mask <= '0;
			irq <= 1'b0;
		end else begin
			if (bus_req.wr && bus_req.addr == ADDR_EVENT_STATUS) begin
				evt_status <= (evt_status & ~bus_req.wdata[EVT_WIDTH-1:0]) | evt_set;
			end else begin
				evt_status <= evt_status | evt_set;
			end
			if (bus_req.wr && bus_req.addr == ADDR_EVENT_MASK) begin
				evt_mask <= bus_req.wdata[EVT_WIDTH-1:0];
			end
			irq <= |(evt_status & evt_mask);
		end
	end

	// ------------------------------------------------------------
	// register read port: data one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (bus_req.rd) begin
			unique case (bus_req.addr)
				ADDR_COMMAND: rdata <= command;
				ADDR_MODE: rdata <= {13'h0000, opmode};
				ADDR_STATE_REPORT: rdata <= report;
				ADDR_EVENT_STATUS: rdata <= {11'h000, evt_status};
				ADDR_EVENT_MASK: rdata <= {11'h000, evt_mask};
				ADDR_FAULT_CTRL: rdata <= {15'h0000, fault_now};
				ADDR_MOTION_CTRL: rdata <= {12'h000, homing_busy, pos_halting,
					set_point_ack, target_reached};
				default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end
endmodule : dcw_decoder

// ---- bench/dcw_decoder_asserts.sv ----
// checker: port-level properties of the control word decoder
`timescale 1ns/1ps
module dcw_decoder_asserts
	import dcw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire dcw_bus_req_type bus_req,
	input wire logic [15:0] rdata,
	input wire logic fault_cause,
	input wire logic motion_done,
	input wire logic homing_done,
	input wire dcw_motion_type motion,
	input wire logic power_stage_on,
	input wire logic irq
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// a command write; windows of 1..4 cover either reading of the latency
	logic cmd_wr;
	assign cmd_wr = bus_req.wr && (bus_req.addr == ADDR_COMMAND);
	a_reserved_read_zero: assert property (
		$past(bus_req.rd) && $past(bus_req.addr) == ADDR_COMMAND |-> rdata[15:9] == 7'h00)
		else $error("command read shows reserved bits");
	a_take_one_pulse: assert property (
		motion.take_set_point |=> !motion.take_set_point)
		else $error("set point takeover longer than one cycle");
	a_homing_start_pulse: assert property (
		motion.homing_start |-> !motion.homing_stop ##1 !motion.homing_start)
		else $error("homing start overlaps stop or lasts");
	a_halt_pos_pulse: assert property (
		motion.halt_position |=> !motion.halt_position)
		else $error("position halt longer than one cycle");
	a_mode_one_hot: assert property (
		$onehot0({motion.take_set_point | motion.halt_position,
			motion.homing_start | motion.homing_stop, motion.interp_enable,
			motion.halt_ramp, motion.halt_torque}))
		else $error("strobes of two modes at once");
	a_voltage_off: assert property (
		cmd_wr && !bus_req.wdata[1] |-> ##[1:4] !power_stage_on)
		else $error("power stage stays on after disable voltage");
	a_interp_off: assert property (
		cmd_wr && !bus_req.wdata[4] |-> ##[1:4] !motion.interp_enable)
		else $error("interpolation enable stays with bit clear");
	a_halt_release: assert property (
		cmd_wr && !bus_req.wdata[8] |-> ##[1:4] !(motion.halt_ramp || motion.halt_torque))
		else $error("ramp halt stays with bit clear");
endmodule : dcw_decoder_asserts

bind dcw_decoder dcw_decoder_asserts u_asserts (.clk_sys(clk_sys), .arst_n(arst_n),
	.bus_req(bus_req), .rdata(rdata), .fault_cause(fault_cause),
	.motion_done(motion_done), .homing_done(homing_done), .motion(motion),
	.power_stage_on(power_stage_on), .irq(irq));

// ---- bench/dcw_master.sv ----
// partner model: fieldbus master issuing register cycles
`timescale 1ns/1ps
module dcw_master
	import dcw_pkg::*;
(
	input wire logic clk_sys,
	output dcw_bus_req_type bus_req,
	input wire logic [15:0] rdata
);
	initial bus_req = '0;
	// one-cycle strobe; released fields are inverted so stale values never match
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
		@(negedge clk_sys);
		d = rdata;
	endtask : rd
endmodule : dcw_master

// ---- bench/testbench.sv ----
// testbench: scenario tasks for the control word decoder
`timescale 1ns/1ps
module testbench
	import dcw_pkg::*;
;
	logic clk_sys;
	logic arst_n;
	logic fault_cause;
	logic motion_done;
	logic homing_done;
	dcw_bus_req_type bus_req;
	logic [15:0] rdata;
	dcw_motion_type motion;
	logic [8:0] mv;
	logic power_stage_on;
	logic irq;
	int n_fail;
	int n_checks;
	assign mv = motion;
	dcw_master u_master (.clk_sys(clk_sys), .bus_req(bus_req), .rdata(rdata));
	dcw_decoder u_dcw_decoder (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req),
		.rdata(rdata), .fault_cause(fault_cause), .motion_done(motion_done),
		.homing_done(homing_done), .motion(motion), .power_stage_on(power_stage_on),
		.irq(irq));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// master polls the report before its next command; a stuck poll ends the run
	task automatic poll(input logic [15:0] m, input logic [15:0] e, input string what);
		logic [15:0] d;
		d = ~e;
		for (int i = 0; i < 20 && (d & m) !== e; i++) u_master.rd(ADDR_STATE_REPORT, d);
		chk(what, e, d & m);
		if ((d & m) !== e) conclude();
	endtask : poll
	task automatic cmd(input logic [15:0] w, input logic [15:0] m, input logic [15:0] e,
		input string what);
		u_master.wr(ADDR_COMMAND, w);
		poll(m, e, what);
	endtask : cmd
	// strobes may be single pulses, so every cycle of a short window is watched
	task automatic see(input int i, input string what);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 8; k++) begin
			@(negedge clk_sys);
			if (mv[i] === 1'b1) hit = 1'b1;
		end
		chk(what, 16'h0001, {15'h0000, hit});
		if (!hit) conclude();
	endtask : see
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_state;
		logic [15:0] d;
		u_master.rd(ADDR_COMMAND, d);
		chk("command reset", COMMAND_RESET, d);
		u_master.rd(4'hf, d);
		chk("unmapped read", 16'h0000, d);
		cmd(16'h000f, 16'h004f, 16'h0040, "enable from disabled");
		cmd(16'h0086, 16'h006f, 16'h0021, "shutdown");
		cmd(16'h0007, 16'h006f, 16'h0023, "switch on");
		cmd(16'h008f, 16'h006f, 16'h0027, "enable op");
		chk("power on", 16'h0001, {15'h0000, power_stage_on});
		cmd(16'h0007, 16'h006f, 16'h0023, "disable op");
		cmd(16'h000b, 16'h004f, 16'h0040, "quick stop off");
		cmd(16'h0006, 16'h006f, 16'h0021, "shutdown again");
		cmd(16'h000f, 16'h006f, 16'h0027, "combined enable");
		cmd(16'h0002, 16'h006f, 16'h0007, "quick stop");
		cmd(16'h0000, 16'h004f, 16'h0040, "disable voltage");
		chk("power off", 16'h0000, {15'h0000, power_stage_on});
		$display("t_state done");
	endtask : t_state
	task automatic t_fault;
		@(posedge clk_sys);
		fault_cause <= 1'b1;
		u_master.wr(ADDR_EVENT_MASK, 16'h0004);
		poll(16'h004f, 16'h000f, "fault entry");
		cmd(16'h0080, 16'h004f, 16'h000f, "reset with cause");
		repeat (8) @(negedge clk_sys);
		chk("irq failed reset", 16'h0001, {15'h0000, irq});
		u_master.wr(ADDR_EVENT_MASK, 16'h0000);
		repeat (3) @(negedge clk_sys);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		u_master.wr(ADDR_EVENT_MASK, 16'h0004);
		u_master.wr(ADDR_EVENT_STATUS, 16'h0004);
		repeat (3) @(negedge clk_sys);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		@(posedge clk_sys);
		fault_cause <= 1'b0;
		cmd(16'h0000, 16'h004f, 16'h000f, "no edge");
		cmd(16'h0080, 16'h004f, 16'h0040, "reset cause gone");
		$display("t_fault done");
	endtask : t_fault
	task automatic go(input logic [15:0] mode);
		u_master.wr(ADDR_COMMAND, 16'h000f);
		u_master.wr(ADDR_MODE, mode);
		cmd(16'h0006, 16'h006f, 16'h0021, "mode shutdown");
		cmd(16'h000f, 16'h006f, 16'h0027, "mode enable");
	endtask : go
	task automatic t_modes;
		logic [15:0] d;
		go(16'h0001);
		u_master.wr(ADDR_COMMAND, 16'h007f);
		see(8, "take set point");
		chk("change immediate", 16'h0001, {15'h0000, mv[7]});
		chk("relative", 16'h0001, {15'h0000, mv[6]});
		u_master.wr(ADDR_COMMAND, 16'h011f);
		see(2, "halt position");
		u_master.rd(ADDR_STATE_REPORT, d);
		chk("not yet reached", 16'h0000, d & 16'h0400);
		// the profile generator reports the stop one cycle long
		@(posedge clk_sys);
		motion_done <= 1'b1;
		@(posedge clk_sys);
		motion_done <= 1'b0;
		poll(16'h0400, 16'h0400, "target reached");
		u_master.wr(ADDR_COMMAND, 16'hfe0f);
		u_master.rd(ADDR_COMMAND, d);
		chk("reserved forced", 16'h000f, d);
		chk("absolute", 16'h0000, {15'h0000, mv[6]});
		go(16'h0006);
		u_master.wr(ADDR_COMMAND, 16'h001f);
		see(5, "homing start");
		u_master.wr(ADDR_COMMAND, 16'h000f);
		see(4, "homing stop");
		@(posedge clk_sys);
		homing_done <= 1'b1;
		poll(16'h1000, 16'h1000, "homing attained");
		// drop the reference flag before the next start so it cannot end it at once
		@(posedge clk_sys);
		homing_done <= 1'b0;
		u_master.wr(ADDR_COMMAND, 16'h001f);
		cmd(16'h011f, 16'h2000, 16'h2000, "homing error");
		u_master.rd(ADDR_EVENT_STATUS, d);
		chk("homing halt event", 16'h0008, d & 16'h0008);
		go(16'h0007);
		u_master.wr(ADDR_COMMAND, 16'h001f);
		see(3, "interp enable");
		poll(16'h1000, 16'h1000, "interp active");
		go(16'h0003);
		u_master.wr(ADDR_COMMAND, 16'h010f);
		see(1, "velocity halt");
		go(16'h0004);
		u_master.wr(ADDR_COMMAND, 16'h010f);
		see(0, "torque halt");
		$display("t_modes done");
	endtask : t_modes
	// ------------------------------------------------------------
	// clock, reset, watchdog and sequence
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end
	initial begin
		n_fail = 0;
		n_checks = 0;
		arst_n = 1'b0;
		fault_cause = 1'b0;
		motion_done = 1'b0;
		homing_done = 1'b0;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_state();
		t_fault();
		t_modes();
		conclude();
	end
endmodule : testbench
